// ---- eeprom_flash_access_control_test.sv ----
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module eeprom_flash_access_control_test
  import nac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, cp, preq, cyc, stb, we, ack, deny, busy;
  logic [3:0] sel;
  logic [5:0] adr;
  logic [31:0] wd, rdat, q;
  logic [13:0] d, word;
  logic [14:0] a;
  logic [14:0] pa [4] = '{15'h01FF, 15'h0200, 15'h3FFF, 15'h4000};
  int err_total, n_tests;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  nac_cpu_model cpu (.i_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc),
    .o_stb(stb), .o_we(we), .o_sel(sel), .o_adr(adr), .o_dat(wd));
  nac_ctrl uut (.I_CLK(clk), .I_RST_N(rst_n), .I_CYC(cyc), .I_STB(stb),
    .I_WE(we), .I_SEL(sel), .I_ADR(adr), .I_DAT(wd), .I_CODE_PROTECT(cp),
    .I_PROG_REQ(preq), .O_DAT(rdat), .O_ACK(ack), .O_PROG_DENIED(deny),
    .O_BUSY(busy));
  task automatic wr(input logic [5:0] ad, input logic [31:0] v);
    cpu.xfer(1'b1, ad, v, q);
  endtask : wr
  task automatic rd(input logic [5:0] ad);
    cpu.xfer(1'b0, ad, 32'h0, q);
  endtask : rd
  function automatic logic pm_ok(input logic [1:0] f, input logic [14:0] x);
    return f == 2'h3 || (f == 2'h2 && x >= 15'h200) ||
      (f == 2'h1 && x >= 15'h4000);
  endfunction : pm_ok
  task automatic start(input logic r, input logic en, input logic bad);
    wr(NAC_OFF_ADRL, a[7:0]);
    if (r) wr(NAC_OFF_ADRH, a[14:8]);
    wr(NAC_OFF_DATL, d[7:0]);
    wr(NAC_OFF_DATH, d[13:8]);
    wr(NAC_OFF_CTRL, {r, 4'h0, en, 2'h0});
    wr(NAC_OFF_UNLOCK, bad ? NAC_KEY2 : NAC_KEY1);
    wr(NAC_OFF_UNLOCK, bad ? NAC_KEY1 : NAC_KEY2);
    wr(NAC_OFF_CTRL, {r, 4'h0, en, 2'h2});
  endtask : start
  task automatic idle();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n == 2000) end_of_test(1'b1);
  endtask : idle
  task automatic fetch(input logic r);
    wr(NAC_OFF_ADRL, a[7:0]);
    if (r) wr(NAC_OFF_ADRH, a[14:8]);
    wr(NAC_OFF_CTRL, {r, 7'h01});
    repeat (2) @(posedge clk);
    rd(NAC_OFF_DATL);
    word[7:0] = q[7:0];
    rd(NAC_OFF_DATH);
    word[13:8] = r ? q[5:0] : 6'h0;
  endtask : fetch
  task automatic end_of_test(input bit hang);
    if (hang) err_total++;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    {rst_n, cp, preq, err_total, n_tests} = '0;
    void'($urandom(32'hd0efda00));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(NAC_OFF_CFG);
    `CHK("cfg", {30'h0, NAC_WRT_RST}, q)
    rd(NAC_OFF_CTRL);
    `CHK("ctrl", 32'h0, q)
    rd(6'h24);
    `CHK("unmapped", 32'h0, q)
    for (int i = 0; i < 6; i++) begin
      a = i == 0 ? 15'h0 : i == 1 ? 15'hFF : 15'($urandom % 256);
      d = {6'h0, i[0] ? ~word[7:0] : 8'($urandom)};
      start(1'b0, 1'b1, 1'b0);
      idle();
      rd(NAC_OFF_STAT);
      `CHK("done", 1'b1, q[NAC_BIT_DONE])
      rd(NAC_OFF_CTRL);
      `CHK("ctrl after", 32'h4, q)
      wr(NAC_OFF_STAT, 32'h1);
      rd(NAC_OFF_STAT);
      `CHK("done clr", 1'b0, q[NAC_BIT_DONE])
      fetch(1'b0);
      `CHK("ee byte", d, word)
    end
    $display("test eeprom done");
    d = ~d & 14'hFF;
    start(1'b0, 1'b0, 1'b0);
    idle();
    start(1'b0, 1'b1, 1'b1);
    idle();
    fetch(1'b0);
    `CHK("refused", ~d & 14'hFF, word)
    start(1'b0, 1'b1, 1'b0);
    wr(NAC_OFF_DATL, 32'h0);
    wr(NAC_OFF_CTRL, 32'h4);
    rd(NAC_OFF_CTRL);
    `CHK("wr held", 1'b1, q[NAC_BIT_WR])
    rd(NAC_OFF_STAT);
    `CHK("busy bit", 1'b1, q[1])
    `CHK("busy pin", 1'b1, busy)
    idle();
    fetch(1'b0);
    `CHK("busy ignore", d, word)
    $display("test refusal done");
    for (int f = 0; f < 4; f++) begin
      for (int j = 0; j < 4; j++) begin
        wr(NAC_OFF_CFG, 32'h3);
        a = pa[j];
        d = 14'($urandom);
        start(1'b1, 1'b1, 1'b0);
        idle();
        wr(NAC_OFF_CFG, f);
        d = ~d;
        start(1'b1, 1'b1, 1'b0);
        idle();
        fetch(1'b1);
        `CHK("pm word", pm_ok(f, a) ? d : ~d, word)
      end
    end
    $display("test program done");
    cp <= 1'b1;
    preq <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("deny", 1'b1, deny)
    rd(NAC_OFF_STAT);
    `CHK("cp bit", 1'b1, q[2])
    a = 15'h5A;
    d = 14'h3C;
    start(1'b0, 1'b1, 1'b0);
    idle();
    fetch(1'b0);
    `CHK("cp byte", d, word)
    cp <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("undeny", 1'b0, deny)
    $display("test protect done");
    end_of_test(1'b0);
  end
endmodule : eeprom_flash_access_control_test

// ---- nac_cpu_model.sv ----
module nac_cpu_model (
  input wire logic i_clk,
  input wire logic i_ack,
  input wire logic [31:0] i_dat,
  output logic o_cyc,
  output logic o_stb,
  output logic o_we,
  output logic [3:0] o_sel,
  output logic [5:0] o_adr,
  output logic [31:0] o_dat
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {o_cyc, o_stb, o_we, o_sel, o_adr, o_dat} = '0;
  end
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we <= w;
    o_sel <= 4'hF;
    o_adr <= a;
    o_dat <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ack !== 1'b1 && n < 20);
    q = i_dat;
    if (i_ack !== 1'b1) eeprom_flash_access_control_test.end_of_test(1'b1);
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    // Released data shows no stale copy of the last write.
    o_dat <= ~d;
    @(posedge i_clk);
  endtask : xfer
endmodule : nac_cpu_model

// ---- nac_ctrl.sv ----
// Functional notes
// - Memories reached only through access registers.
// - Data EEPROM has 256 byte locations.
// - Low data carries byte; low address selects.
// - Data pair forms 14-bit program word.
// - Address pair forms 15-bit program address.
// - Reach 32K words or 256 bytes.
// - EEPROM supports single byte read and write.
// - Byte write erases then programs automatically.
// - Write duration timed by internal timer.
// - Protect field blocks program writes; reads free.
// - Code protection denies external programmer access.
// - Core keeps full access under code protection.
// - Start bits set by software, cleared by hardware.
// - Write needs 55h, AAh, then write start.
// - Write start needs enable; enable kept.
// - Region bit selects EEPROM or program memory.
module nac_ctrl
  import nac_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CYC,
  input wire logic I_STB,
  input wire logic I_WE,
  input wire logic [3:0] I_SEL,
  input wire logic [5:0] I_ADR,
  input wire logic [31:0] I_DAT,
  input wire logic I_CODE_PROTECT,
  input wire logic I_PROG_REQ,
  output logic [31:0] O_DAT,
  output logic O_ACK,
  output logic O_PROG_DENIED,
  output logic O_BUSY
);
  typedef enum logic [1:0] {
    NAC_IDLE,
    NAC_READ,
    NAC_ERASE,
    NAC_PROGRAM
  } nac_state_t;

  typedef enum logic [1:0] {
    NAC_UL_NONE,
    NAC_UL_ONE,
    NAC_UL_TWO
  } nac_unlock_t;

  function automatic logic pm_blocked(input logic [1:0] wrt,
                                      input logic [14:0] a);
    case (wrt)
      2'h3: pm_blocked = 1'b0;
      2'h2: pm_blocked = (a < 15'h0200);
      2'h1: pm_blocked = (a < 15'h4000);
      default: pm_blocked = 1'b1;
    endcase
  endfunction : pm_blocked

  logic rst_m_reg;
  logic rst_n_reg;
  logic cp_m_reg;
  logic cp_reg;
  logic pr_m_reg;
  logic pr_reg;
  nac_state_t state_reg;
  nac_unlock_t unlock_reg;
  logic [15:0] timer_reg;
  logic rd_reg;
  logic wr_reg;
  logic write_enable_bit_reg;
  logic region_reg;
  logic done_reg;
  logic [7:0] datl_reg;
  logic [5:0] dath_reg;
  logic [7:0] adrl_reg;
  logic [6:0] adrh_reg;
  logic [1:0] wrt_reg;
  logic [31:0] rdat_next;

  nac_mem_if ee_bus();
  nac_mem_if pm_bus();

  nac_mem #(.DEPTH(NAC_EE_DEPTH), .AW(8), .DW(8)) u_ee (
    .i_clk(I_CLK),
    .m(ee_bus.mem)
  );
  nac_mem #(.DEPTH(NAC_PM_DEPTH), .AW(NAC_PM_AW), .DW(NAC_PM_DW)) u_pm (
    .i_clk(I_CLK),
    .m(pm_bus.mem)
  );

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_m_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_m_reg <= 1'b1;
      rst_n_reg <= rst_m_reg;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cp_m_reg <= 1'b0;
      cp_reg <= 1'b0;
      pr_m_reg <= 1'b0;
      pr_reg <= 1'b0;
    end else begin
      cp_m_reg <= I_CODE_PROTECT;
      cp_reg <= cp_m_reg;
      pr_m_reg <= I_PROG_REQ;
      pr_reg <= pr_m_reg;
    end
  end

  logic bus_req;
  logic wr_acc;
  logic rd_acc;
  logic wr_start;
  logic busy;
  assign bus_req = I_CYC && I_STB && !O_ACK;
  assign wr_acc = bus_req && I_WE && I_SEL[0];
  assign rd_acc = bus_req && !I_WE;
  assign busy = (state_reg == NAC_ERASE) || (state_reg == NAC_PROGRAM);
  // Write start only after the full unlock sequence with enable set.
  assign wr_start = wr_acc && (I_ADR == 6'(NAC_OFF_CTRL)) &&
                    I_DAT[NAC_BIT_WR] && write_enable_bit_reg &&
                    (unlock_reg == NAC_UL_TWO) && !busy;

  // Single cycle answer to every access, mapped or not; the core never
  // stalls on the register file, only software polls for completion.
  always_ff @(posedge I_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      O_ACK <= 1'b0;
      O_DAT <= 32'h00000000;
    end else begin
      O_ACK <= bus_req;
      O_DAT <= rd_acc ? rdat_next : 32'h00000000;
    end
  end

  always_comb begin
    rdat_next = 32'h00000000;
    case (I_ADR)
      6'(NAC_OFF_CTRL): rdat_next = {24'h000000, region_reg, 4'h0,
                                     write_enable_bit_reg, wr_reg, rd_reg};
      6'(NAC_OFF_DATL): rdat_next = {24'h000000, datl_reg};
      6'(NAC_OFF_DATH): rdat_next = {26'h0000000, dath_reg};
      NAC_OFF_ADRL: rdat_next = {24'h000000, adrl_reg};
      NAC_OFF_ADRH: rdat_next = {25'h0000000, adrh_reg};
      NAC_OFF_STAT: rdat_next = {29'h00000000, cp_reg, busy, done_reg};
      NAC_OFF_CFG: rdat_next = {30'h00000000, wrt_reg};
      default: rdat_next = 32'h00000000; // Unlock port reads as zero.
    endcase
  end

  // Any other write to the unlock port or control breaks the sequence.
  always_ff @(posedge I_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      unlock_reg <= NAC_UL_NONE;
    end else if (wr_acc && I_ADR == 6'(NAC_OFF_UNLOCK)) begin
      if (I_DAT[7:0] == NAC_KEY1) begin
        unlock_reg <= NAC_UL_ONE;
      end else if (I_DAT[7:0] == NAC_KEY2 && unlock_reg == NAC_UL_ONE) begin
        unlock_reg <= NAC_UL_TWO;
      end else begin
        unlock_reg <= NAC_UL_NONE;
      end
    end else if (wr_acc && I_ADR == 6'(NAC_OFF_CTRL)) begin
      unlock_reg <= NAC_UL_NONE;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      write_enable_bit_reg <= 1'b0;
      region_reg <= 1'b0;
      wrt_reg <= NAC_WRT_RST;
    end else if (wr_acc && !busy) begin
      if (I_ADR == 6'(NAC_OFF_CTRL)) begin
        write_enable_bit_reg <= I_DAT[NAC_BIT_WRITE_ENABLE_BIT];
        region_reg <= I_DAT[NAC_BIT_REGION];
      end
      if (I_ADR == NAC_OFF_CFG) begin
        wrt_reg <= I_DAT[1:0];
      end
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      adrl_reg <= NAC_BYTE_RST;
      adrh_reg <= 7'h00;
    end else if (wr_acc && !busy) begin
      if (I_ADR == NAC_OFF_ADRL) begin
        adrl_reg <= I_DAT[7:0];
      end
      if (I_ADR == NAC_OFF_ADRH) begin
        adrh_reg <= I_DAT[6:0];
      end
    end
  end

  // Software cannot clear the start bits; only completion does.
  always_ff @(posedge I_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= NAC_IDLE;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      timer_reg <= 16'h0000;
    end else begin
      case (state_reg)
        NAC_IDLE: begin
          if (wr_start) begin
            wr_reg <= 1'b1;
            timer_reg <= 16'(NAC_WRITE_CYCLES - 1);
            state_reg <= NAC_ERASE;
          end else if (wr_acc && I_ADR == 6'(NAC_OFF_CTRL) &&
                       I_DAT[NAC_BIT_RD]) begin
            rd_reg <= 1'b1;
            state_reg <= NAC_READ;
          end
        end
        NAC_READ: begin
          rd_reg <= 1'b0;
          state_reg <= NAC_IDLE;
        end
        NAC_ERASE: begin
          if (timer_reg == 16'h0000) begin
            timer_reg <= 16'(NAC_WRITE_CYCLES - 1);
            state_reg <= NAC_PROGRAM;
          end else begin
            timer_reg <= timer_reg - 16'h0001;
          end
        end
        NAC_PROGRAM: begin
          if (timer_reg == 16'h0000) begin
            wr_reg <= 1'b0;
            state_reg <= NAC_IDLE;
          end else begin
            timer_reg <= timer_reg - 16'h0001;
          end
        end
        default: state_reg <= NAC_IDLE;
      endcase
    end
  end

  logic pm_wr_ok;
  logic fin;
  assign pm_wr_ok = !pm_blocked(wrt_reg, {adrh_reg, adrl_reg});
  assign fin = (state_reg == NAC_PROGRAM) && (timer_reg == 16'h0000);

  // Erase clears the EEPROM byte to all ones before the new value lands.
  always_comb begin
    ee_bus.addr = {7'h00, adrl_reg};
    ee_bus.wdata = (state_reg == NAC_ERASE) ? 14'h00FF : {6'h00, datl_reg};
    ee_bus.we = !region_reg && ((state_reg == NAC_ERASE &&
                 timer_reg == 16'h0000) || fin);
    pm_bus.addr = {adrh_reg, adrl_reg};
    pm_bus.wdata = {dath_reg, datl_reg};
    pm_bus.we = region_reg && pm_wr_ok && fin;
  end

  // Read data lands two cycles after the start, once memory registers it.
  logic rd_land_reg;
  always_ff @(posedge I_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rd_land_reg <= 1'b0;
      datl_reg <= NAC_BYTE_RST;
      dath_reg <= 6'h00;
    end else begin
      rd_land_reg <= (state_reg == NAC_READ);
      if (rd_land_reg) begin
        if (region_reg) begin
          {dath_reg, datl_reg} <= pm_bus.rdata;
        end else begin
          datl_reg <= ee_bus.rdata[7:0];
        end
      end else if (wr_acc && !busy && I_ADR == 6'(NAC_OFF_DATL)) begin
        datl_reg <= I_DAT[7:0];
      end else if (wr_acc && !busy && I_ADR == 6'(NAC_OFF_DATH)) begin
        dath_reg <= I_DAT[5:0];
      end
    end
  end

  // Completion wins over a clear in the same cycle.
  always_ff @(posedge I_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      done_reg <= 1'b0;
    end else if (fin) begin
      done_reg <= 1'b1;
    end else if (wr_acc && I_ADR == NAC_OFF_STAT && I_DAT[NAC_BIT_DONE]) begin
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      O_PROG_DENIED <= 1'b0;
      O_BUSY <= 1'b0;
    end else begin
      O_PROG_DENIED <= pr_reg && cp_reg;
      O_BUSY <= busy;
    end
  end
endmodule : nac_ctrl

// ---- nac_mem.sv ----
module nac_mem #(
  parameter int DEPTH = 256,
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic i_clk,
  nac_mem_if.mem m
);
  logic [13:0] store [DEPTH];
  logic [13:0] rd_reg;
  always_ff @(posedge i_clk) begin
    if (m.we) begin
      store[m.addr[AW-1:0]] <= m.wdata & 14'((1 << DW) - 1);
    end
    rd_reg <= store[m.addr[AW-1:0]];
  end
  assign m.rdata = rd_reg;
endmodule : nac_mem

// ---- nac_mem_if.sv ----
interface nac_mem_if;
  logic we;
  logic [14:0] addr;
  logic [13:0] wdata;
  logic [13:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : nac_mem_if

// ---- nac_pkg.sv ----
package nac_pkg;
  localparam int NAC_ADDR_W = 4;
  localparam logic [3:0] NAC_OFF_CTRL = 4'h0;
  localparam logic [3:0] NAC_OFF_UNLOCK = 4'h4;
  localparam logic [3:0] NAC_OFF_DATL = 4'h8;
  localparam logic [3:0] NAC_OFF_DATH = 4'hC;
  localparam logic [5:0] NAC_OFF_ADRL = 6'h10;
  localparam logic [5:0] NAC_OFF_ADRH = 6'h14;
  localparam logic [5:0] NAC_OFF_STAT = 6'h18;
  localparam logic [5:0] NAC_OFF_CFG = 6'h1C;
  localparam int NAC_BIT_RD = 0;
  localparam int NAC_BIT_WR = 1;
  localparam int NAC_BIT_WRITE_ENABLE_BIT = 2;
  localparam int NAC_BIT_REGION = 7;
  localparam int NAC_BIT_DONE = 0;
  localparam logic [7:0] NAC_KEY1 = 8'h55;
  localparam logic [7:0] NAC_KEY2 = 8'hAA;
  localparam int NAC_EE_DEPTH = 256;
  localparam int NAC_PM_DEPTH = 32768;
  localparam int NAC_PM_AW = 15;
  localparam int NAC_PM_DW = 14;
  localparam int NAC_CLK_MHZ = 100;
  localparam int NAC_WRITE_TIME_US = 4;
  localparam int NAC_WRITE_CYCLES = NAC_WRITE_TIME_US * NAC_CLK_MHZ;
  localparam logic [1:0] NAC_WRT_RST = 2'h3;
  localparam logic [7:0] NAC_BYTE_RST = 8'h00;
endpackage : nac_pkg

// ---- nac_sva.sv ----
module nac_sva
  import nac_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CYC,
  input wire logic I_STB,
  input wire logic I_WE,
  input wire logic [5:0] I_ADR,
  input wire logic I_CODE_PROTECT,
  input wire logic I_PROG_REQ,
  input wire logic [31:0] O_DAT,
  input wire logic O_ACK,
  input wire logic O_PROG_DENIED,
  input wire logic O_BUSY
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // Counts busy cycles; the write time is too long for a repetition.
  int busy_len_reg;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) busy_len_reg <= 0;
    else busy_len_reg <= O_BUSY ? busy_len_reg + 1 : 0;
  end
  a_ack_follows: assert property (
    I_CYC && I_STB && !O_ACK |=> O_ACK) else $error("no ack");
  a_ack_single: assert property (
    O_ACK |=> !O_ACK) else $error("ack too long");
  a_ack_cause: assert property (
    O_ACK |-> $past(I_CYC && I_STB)) else $error("ack without request");
  a_write_zero: assert property (
    O_ACK && $past(I_WE) |-> O_DAT == 32'h0) else $error("write data out");
  a_unmap_zero: assert property (
    O_ACK && $past(!I_WE && I_ADR > 6'h1F) |-> O_DAT == 32'h0)
    else $error("unmapped read not zero");
  a_unlock_zero: assert property (
    O_ACK && $past(!I_WE && I_ADR == {2'h0, NAC_OFF_UNLOCK})
    |-> O_DAT == 32'h0) else $error("unlock port read not zero");
  a_busy_min: assert property (
    $rose(O_BUSY) |=> O_BUSY[*8]) else $error("busy too short");
  a_busy_time: assert property (
    $fell(O_BUSY) |-> busy_len_reg >= 2 * NAC_WRITE_CYCLES
    && busy_len_reg <= 2 * NAC_WRITE_CYCLES + 2) else $error("write time");
  a_deny_set: assert property (
    (I_CODE_PROTECT && I_PROG_REQ)[*5] |-> O_PROG_DENIED)
    else $error("programmer not denied");
  a_deny_clr: assert property (
    (!I_CODE_PROTECT)[*5] |-> !O_PROG_DENIED) else $error("stale deny");
  c_write: cover property ($fell(O_BUSY));
  c_deny: cover property ($rose(O_PROG_DENIED));
  c_read: cover property (O_ACK && $past(!I_WE));
endmodule : nac_sva
bind nac_ctrl nac_sva u_sva (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_CYC(I_CYC), .I_STB(I_STB), .I_WE(I_WE), .I_ADR(I_ADR),
  .I_CODE_PROTECT(I_CODE_PROTECT), .I_PROG_REQ(I_PROG_REQ),
  .O_DAT(O_DAT), .O_ACK(O_ACK), .O_PROG_DENIED(O_PROG_DENIED),
  .O_BUSY(O_BUSY));
